// >>> hdl/mcs_sequencer.sv
// Machine-cycle sequencer with 8-bit memory bus and serial bit I/O port
`timescale 1ns/1ps
module mcs_sequencer
    import mcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire mcs_cmd_t cmd_type,
    input wire logic [ADDR_W-1:1] cmd_addr,
    input wire logic [WORD_W-1:0] cmd_wdata,
    input wire logic cmd_alu_load,
    input wire logic [BIT_ADDR_W-1:0] cmd_bit_addr,
    input wire logic cmd_bit_data,
    input wire logic mem_ready,
    input wire logic [BYTE_W-1:0] mem_data_in,
    input wire logic bit_input_line,
    input wire logic [2:0] interrupt_level_code,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [WORD_W-1:0] rsp_data,
    output logic rsp_bit,
    output logic [PHASE_COUNT-1:0] clock_phase,
    output logic [ADDR_W-1:1] mem_addr,
    output logic byte_select_address_line,
    output logic mem_enable_n,
    output logic write_enable_n,
    output logic data_bus_in,
    output logic [BYTE_W-1:0] data_out,
    output logic data_out_en_n,
    output logic [BIT_ADDR_W-1:0] bit_address,
    output logic bit_output_line,
    output logic bit_output_strobe,
    output logic reset_request,
    output logic load_request,
    output logic int_request,
    output logic [2:0] int_level
);
    logic sys_tick;

    // Phase generator: the only time base for the sequencer
    mcs_phase_gen #(
        .PHASES(PHASE_COUNT)
    ) u_phase (
        .mclk(mclk),
        .rst_n(rst_n),
        .phase(clock_phase),
        .sys_tick(sys_tick)
    );

    mcs_state_t state_reg, state_next;
    mcs_cmd_t op_reg, op_next;
    logic cyc_reg, cyc_next;
    logic byte_reg, byte_next;
    logic alu_load_reg, alu_load_next;
    logic [WORD_W-1:0] alu_data_reg, alu_data_next;
    logic [BYTE_W-1:0] rd_msb_reg, rd_msb_next;
    logic [WORD_W-1:0] sd_reg, sd_next;
    logic cmd_ready_reg, cmd_ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [WORD_W-1:0] rsp_data_reg, rsp_data_next;
    logic rsp_bit_reg, rsp_bit_next;
    logic [ADDR_W-1:1] mem_addr_reg, mem_addr_next;
    logic byte_sel_reg, byte_sel_next;
    logic mem_en_n_reg, mem_en_n_next;
    logic we_n_reg, we_n_next;
    logic dbin_reg, dbin_next;
    logic [BYTE_W-1:0] dout_reg, dout_next;
    logic dout_en_n_reg, dout_en_n_next;
    logic [BIT_ADDR_W-1:0] bit_addr_reg, bit_addr_next;
    logic bit_out_reg, bit_out_next;
    logic strobe_reg, strobe_next;

    // Interrupt code lines are asynchronous, so they get a two-flop stage
    logic [2:0] ic_meta_reg;
    logic [2:0] ic_sync_reg;
    logic rst_req_reg, rst_req_next;
    logic load_req_reg, load_req_next;
    logic int_req_reg, int_req_next;
    logic [2:0] level_reg, level_next;

    // Machine-cycle sequencing, advanced only on the third-phase tick
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        cyc_next = cyc_reg;
        byte_next = byte_reg;
        alu_load_next = alu_load_reg;
        alu_data_next = alu_data_reg;
        rd_msb_next = rd_msb_reg;
        sd_next = sd_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        rsp_bit_next = rsp_bit_reg;
        mem_addr_next = mem_addr_reg;
        byte_sel_next = byte_sel_reg;
        mem_en_n_next = mem_en_n_reg;
        we_n_next = we_n_reg;
        dbin_next = dbin_reg;
        dout_next = dout_reg;
        dout_en_n_next = 1'b0;
        bit_addr_next = bit_addr_reg;
        bit_out_next = bit_out_reg;
        strobe_next = strobe_reg;
        if (sys_tick) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        op_next = cmd_type;
                        cyc_next = 1'b0;
                        unique case (cmd_type)
                            CMD_ALU: begin
                                // Bus controls are untouched here
                                alu_load_next = cmd_alu_load;
                                alu_data_next = cmd_wdata;
                                state_next = ST_ALU;
                            end
                            CMD_MEM_RD, CMD_MEM_WR: begin
                                byte_next = BYTE_MSB;
                                mem_addr_next = cmd_addr;
                                byte_sel_next = BYTE_MSB;
                                mem_en_n_next = 1'b0;
                                dbin_next = (cmd_type == CMD_MEM_RD);
                                if (cmd_type == CMD_MEM_WR) begin
                                    sd_next = cmd_wdata;
                                    dout_next = cmd_wdata[WORD_W-1:BYTE_W];
                                end
                                state_next = ST_MEM_ADDR;
                            end
                            CMD_BIT_IN, CMD_BIT_OUT: begin
                                bit_addr_next = cmd_bit_addr;
                                if (cmd_type == CMD_BIT_OUT) begin
                                    bit_out_next = cmd_bit_data;
                                end
                                state_next = ST_BIT;
                            end
                            default: begin
                                // Unknown command codes are dropped
                                state_next = ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ALU: begin
                    if (cyc_reg == MC_LAST_CYC) begin
                        if (alu_load_reg) begin
                            sd_next = alu_data_reg;
                            dout_next = alu_data_reg[WORD_W-1:BYTE_W];
                        end
                        rsp_data_next = sd_next;
                        rsp_valid_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        cyc_next = MC_LAST_CYC;
                    end
                end
                ST_MEM_ADDR: begin
                    // Address cycle done; write strobe covers the data cycle
                    if (op_reg == CMD_MEM_WR) begin
                        we_n_next = 1'b0;
                    end
                    state_next = ST_MEM_XFER;
                end
                ST_MEM_XFER: begin
                    // Not ready holds this state one more cycle per sample
                    if (mem_ready) begin
                        we_n_next = 1'b1;
                        if (byte_reg == BYTE_MSB) begin
                            rd_msb_next = mem_data_in;
                            byte_next = BYTE_LSB;
                            byte_sel_next = BYTE_LSB;
                            if (op_reg == CMD_MEM_WR) begin
                                dout_next = sd_reg[BYTE_W-1:0];
                            end
                            state_next = ST_MEM_ADDR;
                        end else begin
                            mem_en_n_next = 1'b1;
                            dbin_next = 1'b0;
                            if (op_reg == CMD_MEM_RD) begin
                                rsp_data_next = {rd_msb_reg, mem_data_in};
                            end else begin
                                rsp_data_next = sd_reg;
                            end
                            rsp_valid_next = 1'b1;
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_BIT: begin
                    if (cyc_reg == MC_LAST_CYC) begin
                        strobe_next = 1'b0;
                        rsp_bit_next = bit_input_line;
                        rsp_valid_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        strobe_next = (op_reg == CMD_BIT_OUT);
                        cyc_next = MC_LAST_CYC;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
        // Requests are taken on a tick only while idle
        cmd_ready_next = (state_next == ST_IDLE);
    end

    // Interrupt code decode, refreshed once per system cycle
    always_comb begin
        rst_req_next = rst_req_reg;
        load_req_next = load_req_reg;
        int_req_next = int_req_reg;
        level_next = level_reg;
        if (sys_tick) begin
            rst_req_next = (ic_sync_reg == IC_RESET_A) ||
                           (ic_sync_reg == IC_RESET_B);
            load_req_next = (ic_sync_reg == IC_LOAD);
            int_req_next = (ic_sync_reg >= IC_LEVEL1) &&
                           (ic_sync_reg <= IC_LEVEL4);
            if (int_req_next) begin
                level_next = ic_sync_reg - IC_LEVEL_BASE;
            end else begin
                level_next = LEVEL_NONE;
            end
        end
    end

    // Sequencer and pin registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg <= CMD_ALU;
            cyc_reg <= 1'b0;
            byte_reg <= BYTE_MSB;
            alu_load_reg <= 1'b0;
            alu_data_reg <= SD_RESET;
            rd_msb_reg <= '0;
            sd_reg <= SD_RESET;
            cmd_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
            rsp_bit_reg <= 1'b0;
            mem_addr_reg <= '0;
            byte_sel_reg <= BYTE_MSB;
            mem_en_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dbin_reg <= 1'b0;
            dout_reg <= '0;
            dout_en_n_reg <= 1'b1;
            bit_addr_reg <= '0;
            bit_out_reg <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            cyc_reg <= cyc_next;
            byte_reg <= byte_next;
            alu_load_reg <= alu_load_next;
            alu_data_reg <= alu_data_next;
            rd_msb_reg <= rd_msb_next;
            sd_reg <= sd_next;
            cmd_ready_reg <= cmd_ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
            rsp_bit_reg <= rsp_bit_next;
            mem_addr_reg <= mem_addr_next;
            byte_sel_reg <= byte_sel_next;
            mem_en_n_reg <= mem_en_n_next;
            we_n_reg <= we_n_next;
            dbin_reg <= dbin_next;
            dout_reg <= dout_next;
            dout_en_n_reg <= dout_en_n_next;
            bit_addr_reg <= bit_addr_next;
            bit_out_reg <= bit_out_next;
            strobe_reg <= strobe_next;
        end
    end

    // Synchroniser and interrupt request registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ic_meta_reg <= IC_IDLE;
            ic_sync_reg <= IC_IDLE;
            rst_req_reg <= 1'b0;
            load_req_reg <= 1'b0;
            int_req_reg <= 1'b0;
            level_reg <= LEVEL_NONE;
        end else begin
            ic_meta_reg <= interrupt_level_code;
            ic_sync_reg <= ic_meta_reg;
            rst_req_reg <= rst_req_next;
            load_req_reg <= load_req_next;
            int_req_reg <= int_req_next;
            level_reg <= level_next;
        end
    end

    assign cmd_ready = cmd_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_data = rsp_data_reg;
    assign rsp_bit = rsp_bit_reg;
    assign mem_addr = mem_addr_reg;
    assign byte_select_address_line = byte_sel_reg;
    assign mem_enable_n = mem_en_n_reg;
    assign write_enable_n = we_n_reg;
    assign data_bus_in = dbin_reg;
    assign data_out = dout_reg;
    assign data_out_en_n = dout_en_n_reg;
    assign bit_address = bit_addr_reg;
    assign bit_output_line = bit_out_reg;
    assign bit_output_strobe = strobe_reg;
    assign reset_request = rst_req_reg;
    assign load_request = load_req_reg;
    assign int_request = int_req_reg;
    assign int_level = level_reg;
endmodule // mcs_sequencer

// >>> shared/mcs_pkg.sv
// Constants and types shared by the machine-cycle sequencer files
package mcs_pkg;
    // Internal clock: four phases of one input clock period each
    localparam int PHASE_COUNT = 4;
    // Zero-based index of the third phase, the reference for all pins
    localparam int LAUNCH_PHASE = 2;
    // A basic machine cycle is two system clock cycles, index 0 and 1
    localparam logic MC_LAST_CYC = 1'h1;
    // A byte transfer with no wait state also takes two system cycles
    localparam logic BYTE_MSB = 1'h0;
    localparam logic BYTE_LSB = 1'h1;
    // Bus widths
    localparam int ADDR_W = 14;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    // 2048 input bits and 2048 output bits
    localparam int BIT_ADDR_W = 11;
    // Reset values
    localparam logic [WORD_W-1:0] SD_RESET = 16'h0000;
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    // Interrupt level code points
    localparam logic [2:0] IC_RESET_A = 3'h0;
    localparam logic [2:0] IC_RESET_B = 3'h1;
    localparam logic [2:0] IC_LOAD = 3'h2;
    localparam logic [2:0] IC_LEVEL1 = 3'h3;
    localparam logic [2:0] IC_LEVEL4 = 3'h6;
    localparam logic [2:0] IC_IDLE = 3'h7;
    // Offset from a level code to its level number
    localparam logic [2:0] IC_LEVEL_BASE = 3'h2;

    typedef enum logic [2:0] {
        CMD_ALU = 3'h0,
        CMD_MEM_RD = 3'h1,
        CMD_MEM_WR = 3'h2,
        CMD_BIT_IN = 3'h3,
        CMD_BIT_OUT = 3'h4
    } mcs_cmd_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ALU = 5'b00010,
        ST_MEM_ADDR = 5'b00100,
        ST_MEM_XFER = 5'b01000,
        ST_BIT = 5'b10000
    } mcs_state_t;
endpackage

// >>> hdl/mcs_phase_gen.sv
// Four-phase internal clock generator driven by the input clock
`timescale 1ns/1ps
module mcs_phase_gen
    import mcs_pkg::*;
#(
    parameter int PHASES = PHASE_COUNT
) (
    input wire logic mclk,
    input wire logic rst_n,
    output logic [PHASES-1:0] phase,
    output logic sys_tick
);
    localparam int CW = $clog2(PHASES);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic [PHASES-1:0] phase_reg;
    logic [PHASES-1:0] phase_next;
    logic tick_reg;
    logic tick_next;

    // Phase counter; the tick marks the third phase of each system cycle
    always_comb begin
        if (cnt_reg == CW'(PHASES - 1)) begin
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
        for (int g = 0; g < PHASES; g++) begin
            phase_next[g] = (cnt_next == CW'(g));
        end
        tick_next = (cnt_next == CW'(LAUNCH_PHASE));
    end

    // Registered so that the tick and phases are clean flop outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            phase_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            tick_reg <= tick_next;
        end
    end

    assign phase = phase_reg;
    assign sys_tick = tick_reg;
endmodule // mcs_phase_gen

// >>> tb/mcs_far_model.sv
// Behavioural memory, bit I/O devices and ready handshake facing the block
`timescale 1ns/1ps
module mcs_far_model
    import mcs_pkg::*;
(
    input wire logic mclk,
    input wire logic [PHASE_COUNT-1:0] clock_phase,
    input wire logic [ADDR_W-1:1] mem_addr,
    input wire logic byte_select_address_line,
    input wire logic mem_enable_n,
    input wire logic write_enable_n,
    input wire logic data_bus_in,
    input wire logic [BYTE_W-1:0] data_out,
    input wire logic [BIT_ADDR_W-1:0] bit_address,
    input wire logic bit_output_line,
    input wire logic bit_output_strobe,
    input wire logic [1:0] waits,
    output logic mem_ready,
    output logic [BYTE_W-1:0] mem_data_in,
    output logic bit_input_line
);
    logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic out_bits [0:(1<<BIT_ADDR_W)-1];
    logic [1:0] cnt, key;
    initial begin
        mem_ready = 1'b0;
        mem_data_in = 8'h00;
        bit_input_line = 1'b0;
        key = 2'h3;
    end
    // Answers only on ticks, so every input stays synchronous
    always @(posedge mclk) begin
        if (clock_phase[LAUNCH_PHASE]) begin
            if (mem_enable_n) begin
                key <= 2'h3;
                mem_ready <= 1'b0;
            end else if (key != {1'b0, byte_select_address_line}) begin
                // Each new byte is held off by the commanded wait count
                key <= {1'b0, byte_select_address_line};
                cnt <= waits;
                mem_ready <= (waits == 2'h0);
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
                mem_ready <= (cnt == 2'h1);
            end
            // Released bus inverts on every tick, so it alternates between the stale byte and its inverse
            if (!mem_enable_n && data_bus_in) begin
                mem_data_in <= mem[{mem_addr, byte_select_address_line}];
            end else begin
                mem_data_in <= ~mem_data_in;
            end
            if (!mem_enable_n && !write_enable_n && mem_ready) begin
                mem[{mem_addr, byte_select_address_line}] <= data_out;
            end
            // Input bit pattern is the parity of its address
            bit_input_line <= ^bit_address;
            if (bit_output_strobe) begin
                out_bits[bit_address] <= bit_output_line;
            end
        end
    end
endmodule // mcs_far_model

// >>> tb/mcs_sequencer_chk.sv
// Concurrent checks on the machine-cycle sequencer ports
`timescale 1ns/1ps
module mcs_sequencer_chk
    import mcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire mcs_cmd_t cmd_type,
    input wire logic [BIT_ADDR_W-1:0] cmd_bit_addr,
    input wire logic cmd_bit_data,
    input wire logic [2:0] interrupt_level_code,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [PHASE_COUNT-1:0] clock_phase,
    input wire logic [ADDR_W-1:1] mem_addr,
    input wire logic byte_select_address_line,
    input wire logic mem_enable_n,
    input wire logic write_enable_n,
    input wire logic data_bus_in,
    input wire logic [BYTE_W-1:0] data_out,
    input wire logic data_out_en_n,
    input wire logic [BIT_ADDR_W-1:0] bit_address,
    input wire logic bit_output_line,
    input wire logic bit_output_strobe,
    input wire logic load_request,
    input wire logic int_request,
    input wire logic [2:0] int_level
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic [PHASE_COUNT-1:0] phase_rot;
    // Requests are only taken on the edge that ends the third phase
    assign take = cmd_valid && cmd_ready && clock_phase[LAUNCH_PHASE];
    assign phase_rot = {clock_phase[2:0], clock_phase[3]};

    a_phase_rotate: assert property ($onehot(clock_phase) |=>
        clock_phase == $past(phase_rot)) else $error("phase did not rotate");
    a_short_cycle: assert property (take && cmd_type inside
        {CMD_ALU, CMD_BIT_IN, CMD_BIT_OUT} |=> !cmd_ready && !rsp_valid
        ##1 (!rsp_valid)[*7] ##1 (rsp_valid && cmd_ready))
        else $error("machine cycle not two system cycles");
    a_alu_quiet: assert property (take && cmd_type == CMD_ALU |=>
        ($stable(mem_enable_n) && $stable(write_enable_n)
        && $stable(bit_address) && $stable(bit_output_strobe)
        && $stable(mem_addr))[*8]) else $error("ALU cycle moved controls");
    a_mem_floor: assert property (take && cmd_type inside
        {CMD_MEM_RD, CMD_MEM_WR} |=> (!mem_enable_n)[*8] ##8 !mem_enable_n)
        else $error("memory cycle shorter than four system cycles");
    a_msb_first: assert property ($fell(mem_enable_n) |->
        !byte_select_address_line) else $error("word did not start on MSB");
    a_lsb_last: assert property ($rose(mem_enable_n) |->
        byte_select_address_line && rsp_valid && write_enable_n)
        else $error("memory cycle did not end on LSB answer");
    a_bit_out: assert property (take && cmd_type == CMD_BIT_OUT |=>
        bit_address == $past(cmd_bit_addr)
        && bit_output_line == $past(cmd_bit_data) ##3 !bit_output_strobe
        ##1 bit_output_strobe[*4] ##1 !bit_output_strobe)
        else $error("bit output strobe misplaced");
    a_bit_in: assert property (take && cmd_type == CMD_BIT_IN |=>
        bit_address == $past(cmd_bit_addr) && !bit_output_strobe
        ##1 (!bit_output_strobe)[*7]) else $error("bit input strobed");
    a_read_hold: assert property (data_bus_in && $past(data_bus_in) |->
        $stable(data_out) && write_enable_n)
        else $error("data bus changed during read");
    a_bus_driven: assert property ($past(rst_n) |-> !data_out_en_n)
        else $error("data bus released after reset");
    a_load_code: assert property ((interrupt_level_code == IC_LOAD)[*8]
        |-> load_request) else $error("load code not decoded");
    a_level_code: assert property ((interrupt_level_code == IC_LEVEL4)
        [*8] |-> int_request && int_level == 3'h4)
        else $error("level four code not decoded");

    c_mem_wr: cover property (take && cmd_type == CMD_MEM_WR);
    c_bit_strobe: cover property ($rose(bit_output_strobe));
    c_alu: cover property (take && cmd_type == CMD_ALU);
endmodule // mcs_sequencer_chk

bind mcs_sequencer mcs_sequencer_chk u_chk (.mclk, .rst_n, .cmd_valid,
    .cmd_type, .cmd_bit_addr, .cmd_bit_data, .interrupt_level_code,
    .cmd_ready, .rsp_valid, .clock_phase, .mem_addr, .byte_select_address_line,
    .mem_enable_n, .write_enable_n, .data_bus_in, .data_out, .data_out_en_n,
    .bit_address, .bit_output_line, .bit_output_strobe, .load_request,
    .int_request, .int_level);

// >>> tb/tb_cpu_machine_cycle_sequencer.sv
// Self-checking bench for the machine-cycle sequencer
`timescale 1ns/1ps
module tb_cpu_machine_cycle_sequencer
    import mcs_pkg::*;
;
    typedef struct {logic ud; logic [WORD_W-1:0] d;
        logic ub; logic b;} mcs_exp_t;
    logic mclk, rst_n, cmd_valid, cmd_alu_load, cmd_bit_data, mem_ready;
    mcs_cmd_t cmd_type;
    logic [ADDR_W-1:1] cmd_addr, mem_addr;
    logic [WORD_W-1:0] cmd_wdata, rsp_data, latch;
    logic [BIT_ADDR_W-1:0] cmd_bit_addr, bit_address, ba;
    logic [BYTE_W-1:0] mem_data_in, data_out;
    logic [2:0] interrupt_level_code, int_level, code;
    logic bit_input_line, cmd_ready, rsp_valid, rsp_bit, bd;
    logic [PHASE_COUNT-1:0] clock_phase;
    logic byte_select_address_line, mem_enable_n, write_enable_n, data_bus_in;
    logic data_out_en_n, bit_output_line, bit_output_strobe;
    logic reset_request, load_request, int_request;
    logic [1:0] waits;
    logic [ADDR_W-1:1] addrs [4];
    logic [WORD_W-1:0] words [4];
    int n_errors, n_checks, seed;
    mcs_exp_t exp_q [$], e;

    mcs_sequencer u_dut (.mclk, .rst_n, .cmd_valid, .cmd_type, .cmd_addr,
        .cmd_wdata, .cmd_alu_load, .cmd_bit_addr, .cmd_bit_data, .mem_ready,
        .mem_data_in, .bit_input_line, .interrupt_level_code, .cmd_ready,
        .rsp_valid, .rsp_data, .rsp_bit, .clock_phase, .mem_addr,
        .byte_select_address_line, .mem_enable_n, .write_enable_n,
        .data_bus_in, .data_out, .data_out_en_n, .bit_address,
        .bit_output_line, .bit_output_strobe, .reset_request, .load_request,
        .int_request, .int_level);
    mcs_far_model u_far (.mclk, .clock_phase, .mem_addr,
        .byte_select_address_line, .mem_enable_n, .write_enable_n,
        .data_bus_in, .data_out, .bit_address, .bit_output_line,
        .bit_output_strobe, .waits, .mem_ready, .mem_data_in, .bit_input_line);

    task automatic cmp16(input logic [WORD_W-1:0] got,
        input logic [WORD_W-1:0] want);
        n_checks++;
        if (got !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, want);
        end
    endtask
    task automatic cmp1(input logic got, input logic want);
        cmp16({15'h0000, got}, {15'h0000, want});
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One request: wait to be taken, then time the answer in clock edges
    task automatic issue(input mcs_cmd_t t, input logic [ADDR_W-1:1] a,
        input logic [WORD_W-1:0] wd, input logic ld,
        input logic [BIT_ADDR_W-1:0] bad, input logic bdat, input int lat);
        int k = 0;
        cmd_type <= t;
        cmd_addr <= a;
        cmd_wdata <= wd;
        cmd_alu_load <= ld;
        cmd_bit_addr <= bad;
        cmd_bit_data <= bdat;
        cmd_valid <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (!(cmd_ready === 1'b1 && clock_phase[LAUNCH_PHASE])
            && k < 50);
        cmd_valid <= 1'b0;
        k = (k >= 50) ? 200 : 0;
        while (lat > 0 && rsp_valid !== 1'b1 && k < 200) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 200) begin
            n_errors++;
            stop_test();
        end
        if (lat > 0) cmp16(16'(k), 16'(lat));
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Answers are paired with the oldest note; a stray answer is an error
    always @(posedge mclk) begin
        if (rst_n === 1'b1 && rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time,
                    rsp_data, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                if (e.ud) cmp16(rsp_data, e.d);
                if (e.ub) cmp1(rsp_bit, e.b);
            end
        end
    end

    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_type = CMD_ALU;
        cmd_addr = '0;
        cmd_wdata = 16'h0000;
        cmd_alu_load = 1'b0;
        cmd_bit_addr = '0;
        cmd_bit_data = 1'b0;
        interrupt_level_code = IC_IDLE;
        waits = 2'h0;
        n_errors = 0;
        n_checks = 0;
        seed = $urandom(89);
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // Word writes then reads, each byte stretched by 0..2 waits
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                addrs[i] = {11'($urandom), 2'(i)};
                words[i] = 16'($urandom);
            end
            waits <= 2'(i % 3);
            exp_q.push_back('{1'b1, words[i % 4], 1'b0, 1'b0});
            issue((i < 4) ? CMD_MEM_WR : CMD_MEM_RD, addrs[i % 4], words[i % 4],
                1'b0, '0, 1'b0, 4 * (4 + 2 * (i % 3)) + 1);
            cmp16({u_far.mem[{addrs[i % 4], 1'b0}],
                u_far.mem[{addrs[i % 4], 1'b1}]}, words[i % 4]);
        end
        // Loading and plain ALU cycles, then a read that must not disturb it
        latch = 16'($urandom);
        exp_q.push_back('{1'b1, latch, 1'b0, 1'b0});
        issue(CMD_ALU, '0, latch, 1'b1, '0, 1'b0, 9);
        cmp16({8'h00, data_out}, {8'h00, latch[15:8]});
        exp_q.push_back('{1'b1, latch, 1'b0, 1'b0});
        issue(CMD_ALU, '0, ~latch, 1'b0, '0, 1'b0, 9);
        waits <= 2'h0;
        exp_q.push_back('{1'b1, words[0], 1'b0, 1'b0});
        issue(CMD_MEM_RD, addrs[0], 16'h0000, 1'b0, '0, 1'b0, 17);
        cmp16({8'h00, data_out}, {8'h00, latch[15:8]});
        // Bit output then input at both ends of the bit space and one inside
        for (int j = 0; j < 3; j++) begin
            ba = (j == 0) ? 11'h000 : (j == 1) ? 11'h7ff : 11'($urandom);
            bd = 1'($urandom);
            exp_q.push_back('{1'b0, 16'h0000, 1'b0, 1'b0});
            issue(CMD_BIT_OUT, '0, 16'h0000, 1'b0, ba, bd, 9);
            cmp1(u_far.out_bits[ba], bd);
            exp_q.push_back('{1'b0, 16'h0000, 1'b1, ^ba});
            issue(CMD_BIT_IN, '0, 16'h0000, 1'b0, ba, ~bd, 9);
        end
        // An undefined command is swallowed without an answer
        issue(mcs_cmd_t'(3'h5), '0, 16'h0000, 1'b0, '0, 1'b0, 0);
        repeat (12) @(posedge mclk);
        cmp1(cmd_ready, 1'b1);
        // Every interrupt code, changed with no regard to the phase
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            interrupt_level_code <= code;
            repeat (10) @(posedge mclk);
            cmp1(reset_request, code <= IC_RESET_B);
            cmp1(load_request, code == IC_LOAD);
            cmp1(int_request, code >= IC_LEVEL1 && code <= IC_LEVEL4);
            cmp16({13'h0000, int_level}, {13'h0000, (code >= IC_LEVEL1
                && code <= IC_LEVEL4) ? code - IC_LEVEL_BASE : LEVEL_NONE});
        end
        stop_test();
    end
endmodule // tb_cpu_machine_cycle_sequencer
